// ==== rtl/passive_serial_config_slave.sv ====
// Purpose: Passive serial configuration front end: stages, status and done handshakes
// Assumes: Status and done lines are open drain with external pull-ups
// Notes: Config bytes leave through a FIFO toward the configuration memory
module passive_serial_config_slave
    import ps_cfg_pkg::*;
#(
    parameter int unsigned POR_CYCLES = POR_CYCLES_DEF,
    parameter int unsigned CFG_BYTES = CFG_BYTES_DEF
)
(
    // System clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Link clock and serial data
    input wire logic config_bit_clock,
    input wire logic serial_config_data,
    // Configuration request pin
    input wire logic config_request_n,
    // Open-drain status line
    input wire logic config_status_n_in,
    output logic config_status_n_out,
    output logic config_status_n_oe_n,
    // Open-drain done line
    input wire logic config_done_in,
    output logic config_done_out,
    output logic config_done_oe_n,
    // Chain enables
    input wire logic chain_enable_in_n,
    output logic chain_enable_out_n,
    // Initialization clock choice
    input wire logic user_init_clock,
    input wire logic user_init_clock_en,
    // Configuration memory side
    output logic cfg_out_valid,
    output logic [BYTE_W-1:0] cfg_out_data,
    input wire logic cfg_out_ready,
    input wire logic cfg_data_error,
    // Device state
    output logic user_io_oe_n,
    output logic user_mode,
    output logic config_error_seen
);

    typedef struct packed {
        cfg_state_t state;
        logic [31:0] count;
        logic [31:0] bytes;
        logic [8:0] init_ticks;
        logic [2:0] osc_cnt;
        logic req_meta;
        logic req_s;
        logic stat_meta;
        logic stat_s;
        logic done_meta;
        logic done_s;
        logic chain_meta;
        logic chain_s;
        logic uclk_meta;
        logic uclk_s;
        logic uclk_prev;
        logic tog_meta;
        logic tog_s;
        logic tog_prev;
        logic req_low_seen;
        logic accept;
        byte_slot_t pend;
        logic status_out;
        logic status_oe_n;
        logic done_out;
        logic done_oe_n;
        logic chain_out_n;
        logic user_oe_n;
        logic user_mode;
        logic error_seen;
    } cfg_regs_t;

    cfg_regs_t s_r;
    cfg_regs_t s_nxt;
    logic [BYTE_W-1:0] cap_byte;
    logic cap_toggle;
    logic fifo_in_ready;
    logic byte_evt;
    logic init_tick;
    logic fault;
    logic line_drop;

    serial_bit_capture u_capture (
        .config_bit_clock(config_bit_clock),
        .rst(rst),
        .accept_level(s_r.accept),
        .serial_config_data(serial_config_data),
        .byte_hold(cap_byte),
        .byte_toggle(cap_toggle)
    );

    // A full FIFO stalls the pending slot; a second byte then is an overrun
    cfg_byte_fifo #(
        .WIDTH(BYTE_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(ref_clk),
        .rst(rst),
        .in_valid(s_r.pend.valid),
        .in_data(s_r.pend.data),
        .in_ready(fifo_in_ready),
        .out_valid(cfg_out_valid),
        .out_data(cfg_out_data),
        .out_ready(cfg_out_ready)
    );

    assign config_status_n_out = s_r.status_out;
    assign config_status_n_oe_n = s_r.status_oe_n;
    assign config_done_out = s_r.done_out;
    assign config_done_oe_n = s_r.done_oe_n;
    assign chain_enable_out_n = s_r.chain_out_n;
    assign user_io_oe_n = s_r.user_oe_n;
    assign user_mode = s_r.user_mode;
    assign config_error_seen = s_r.error_seen;

    assign byte_evt = s_r.tog_s ^ s_r.tog_prev;
    assign line_drop = !s_r.req_s || !s_r.stat_s;
    assign fault = cfg_data_error || (byte_evt && s_r.pend.valid && !fifo_in_ready);
    // The internal oscillator is a divided ref_clk; the user clock is edge-detected
    assign init_tick = user_init_clock_en ? (s_r.uclk_s && !s_r.uclk_prev)
                                          : (s_r.osc_cnt == 3'(OSC_DIV - 1));

    always_comb
    begin
        s_nxt = s_r;
        // Pin synchronisers
        s_nxt.req_meta = config_request_n;
        s_nxt.req_s = s_r.req_meta;
        s_nxt.stat_meta = config_status_n_in;
        s_nxt.stat_s = s_r.stat_meta;
        s_nxt.done_meta = config_done_in;
        s_nxt.done_s = s_r.done_meta;
        s_nxt.chain_meta = chain_enable_in_n;
        s_nxt.chain_s = s_r.chain_meta;
        s_nxt.uclk_meta = user_init_clock;
        s_nxt.uclk_s = s_r.uclk_meta;
        s_nxt.uclk_prev = s_r.uclk_s;
        s_nxt.tog_meta = cap_toggle;
        s_nxt.tog_s = s_r.tog_meta;
        s_nxt.tog_prev = s_r.tog_s;
        s_nxt.osc_cnt = s_r.osc_cnt + 3'h1;
        s_nxt.status_out = 1'b0;
        s_nxt.done_out = 1'b0;
        // Only configure while chained in, status high, and bytes remain
        s_nxt.accept = (s_r.state == ST_CONFIG) && s_r.stat_s && !s_r.chain_s
                       && (s_r.bytes < 32'(CFG_BYTES));
        // Pending slot into FIFO
        if (s_r.pend.valid && fifo_in_ready)
        begin
            s_nxt.pend.valid = 1'b0;
            s_nxt.bytes = inc32(s_r.bytes);
        end
        if (byte_evt && (s_r.state == ST_CONFIG) && !s_nxt.pend.valid)
        begin
            s_nxt.pend.valid = 1'b1;
            s_nxt.pend.data = cap_byte;
        end
        case (s_r.state)
            ST_POR:
            begin
                // Status held low, user pins off, for the whole power-on reset
                s_nxt.status_oe_n = 1'b0;
                s_nxt.user_oe_n = 1'b1;
                s_nxt.count = inc32(s_r.count);
                if (s_r.count >= POR_CYCLES - 1)
                begin
                    s_nxt.state = ST_RESET;
                    s_nxt.status_oe_n = 1'b1;
                    s_nxt.count = '0;
                end
            end
            ST_RESET:
            begin
                s_nxt.done_oe_n = 1'b0;
                s_nxt.chain_out_n = 1'b1;
                s_nxt.user_oe_n = 1'b1;
                s_nxt.user_mode = 1'b0;
                s_nxt.bytes = '0;
                s_nxt.pend.valid = 1'b0;
                // Status is pulled low while the request line is low
                s_nxt.status_oe_n = s_r.req_s;
                if (!s_r.req_s)
                begin
                    s_nxt.req_low_seen = 1'b1;
                end
                // Leave only on a fresh rising request and high status
                if (s_r.req_low_seen && !line_drop)
                begin
                    s_nxt.state = ST_CONFIG;
                    s_nxt.status_oe_n = 1'b1;
                end
            end
            ST_CONFIG:
            begin
                s_nxt.status_oe_n = 1'b1;
                if ((s_r.bytes >= 32'(CFG_BYTES)) && !s_r.pend.valid)
                begin
                    // Own share is loaded: release done, pass the chain on
                    s_nxt.done_oe_n = 1'b1;
                    s_nxt.chain_out_n = 1'b0;
                end
                if (fault)
                begin
                    s_nxt.state = ST_ERROR;
                    s_nxt.status_oe_n = 1'b0;
                    s_nxt.error_seen = 1'b1;
                    s_nxt.count = '0;
                end
                else if (line_drop)
                begin
                    // Another device or the host pulled a line: stop here
                    s_nxt.state = ST_RESET;
                    s_nxt.req_low_seen = 1'b0;
                end
                else if (s_r.done_s)
                begin
                    // Whole chain released done together
                    s_nxt.state = ST_INIT;
                    s_nxt.init_ticks = '0;
                end
            end
            ST_INIT:
            begin
                if (line_drop)
                begin
                    s_nxt.state = ST_RESET;
                    s_nxt.req_low_seen = 1'b0;
                end
                else if (init_tick)
                begin
                    s_nxt.init_ticks = s_r.init_ticks + 9'h1;
                    if (s_r.init_ticks == 9'(INIT_TICKS - 1))
                    begin
                        s_nxt.state = ST_USER;
                        s_nxt.user_oe_n = 1'b0;
                        s_nxt.user_mode = 1'b1;
                    end
                end
            end
            ST_USER:
            begin
                if (!s_r.req_s)
                begin
                    s_nxt.state = ST_RESET;
                    s_nxt.req_low_seen = 1'b1;
                end
            end
            ST_ERROR:
            begin
                // No automatic restart: a new low-high request is needed
                s_nxt.status_oe_n = 1'b0;
                s_nxt.count = inc32(s_r.count);
                if (s_r.count >= 32'(ERR_HOLD_CYCLES - 1))
                begin
                    s_nxt.state = ST_RESET;
                    s_nxt.req_low_seen = 1'b0;
                    s_nxt.count = '0;
                end
            end
            default:
            begin
                s_nxt.state = ST_RESET;
                s_nxt.req_low_seen = 1'b0;
            end
        endcase
        if (cfg_data_error)
        begin
            s_nxt.error_seen = 1'b1;
        end
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            s_r <= '0;
            s_r.status_oe_n <= STATUS_OE_N_RST;
            s_r.done_oe_n <= DONE_OE_N_RST;
            s_r.user_oe_n <= USER_OE_N_RST;
            s_r.chain_out_n <= CHAIN_OUT_N_RST;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    // Checks
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    sequence seq_reset_ready;
        (s_r.state == ST_RESET) && s_r.req_low_seen && s_r.req_s && s_r.stat_s;
    endsequence

    sequence seq_config_done;
        (s_r.state == ST_CONFIG) && s_r.done_s && !line_drop && !fault;
    endsequence

    AST_POR_HOLDS_LINES: assert property (
        (s_r.state == ST_POR) |-> (!config_status_n_oe_n && user_io_oe_n && !user_mode))
        else $error("status not low or user pins active during power-on reset");

    AST_POR_RELEASE: assert property (
        ((s_r.state == ST_RESET) && ($past(s_r.state) == ST_POR))
        |-> (config_status_n_oe_n && user_io_oe_n))
        else $error("status not released or user pins driven after power-on reset");

    AST_STAGE_ORDER: assert property (
        ((s_r.state == ST_INIT) && ($past(s_r.state) != ST_INIT))
        |-> ($past(s_r.state) == ST_CONFIG))
        else $error("initialization entered from other than configuration");

    AST_RESET_HOLD: assert property (
        ((s_r.state == ST_RESET) && line_drop) |=> (s_r.state == ST_RESET))
        else $error("reset stage left while a line was low");

    AST_ENTER_CONFIG: assert property (
        seq_reset_ready |=> (s_r.state == ST_CONFIG) ##1 config_status_n_oe_n)
        else $error("rising request did not start configuration");

    AST_CONFIG_RELEASE: assert property (
        ((s_r.state == ST_CONFIG) && !fault) |=> config_status_n_oe_n)
        else $error("status driven during configuration");

    AST_NO_EARLY_DATA: assert property (
        !s_r.stat_s |=> !s_r.accept)
        else $error("data accepted while status low");

    AST_DONE_STARTS_INIT: assert property (
        seq_config_done |=> (s_r.state == ST_INIT) && (s_r.init_ticks == 9'h0))
        else $error("done rise did not start initialization");

    AST_STATUS_LOW_STOPS: assert property (
        (((s_r.state == ST_CONFIG) || (s_r.state == ST_INIT)) && !s_r.stat_s && !fault)
        |=> (s_r.state == ST_RESET) ##1 !s_r.accept)
        else $error("configuration kept going with status low");

    AST_INIT_COUNT: assert property (
        ((s_r.state == ST_USER) && ($past(s_r.state) == ST_INIT))
        |-> (($past(s_r.init_ticks) == 9'(INIT_TICKS - 1)) && !user_io_oe_n && user_mode))
        else $error("user mode entered at wrong initialization count");

endmodule : passive_serial_config_slave

// ==== rtl/ps_cfg_pkg.sv ====
// Purpose: Shared constants and types of the passive serial configuration front end
// Assumes: ref_clk at 250 MHz; one byte of configuration data per eight link clocks
// Notes: Long counts are only defaults; the top module takes them as parameters
package ps_cfg_pkg;

    // Timing
    localparam int unsigned REF_CLK_KHZ = 250000;
    localparam int unsigned POR_TIME_MS = 100;
    localparam int unsigned POR_CYCLES_DEF = POR_TIME_MS * REF_CLK_KHZ;
    localparam int unsigned INIT_TICKS = 299;
    localparam int unsigned OSC_DIV = 8;
    localparam int unsigned ERR_HOLD_CYCLES = 16;

    // Stream shape
    localparam int unsigned BYTE_W = 8;
    localparam int unsigned FIFO_DEPTH = 16;
    localparam int unsigned CFG_BYTES_DEF = 1024;

    // Reset values of the pin controls (oe_n high = released)
    localparam logic STATUS_OE_N_RST = 1'b0;
    localparam logic DONE_OE_N_RST = 1'b0;
    localparam logic USER_OE_N_RST = 1'b1;
    localparam logic CHAIN_OUT_N_RST = 1'b1;

    typedef enum logic [2:0] {
        ST_POR = 3'h0,
        ST_RESET = 3'h1,
        ST_CONFIG = 3'h2,
        ST_INIT = 3'h3,
        ST_USER = 3'h4,
        ST_ERROR = 3'h5
    } cfg_state_t;

    typedef struct packed {
        logic valid;
        logic [BYTE_W-1:0] data;
    } byte_slot_t;

    function automatic logic [31:0] inc32(input logic [31:0] v);
        inc32 = v + 32'h1;
    endfunction : inc32

endpackage : ps_cfg_pkg

// ==== rtl/cfg_byte_fifo.sv ====
// Purpose: Byte FIFO between the serial capture and the configuration memory port
// Assumes: Single clock; push and pop may happen in the same cycle
// Notes: in_ready falls when full, which stalls the pending byte in the loader
module cfg_byte_fifo
    import ps_cfg_pkg::*;
#(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned DEPTH = 16
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Filling side
    input wire logic in_valid,
    input wire logic [WIDTH-1:0] in_data,
    output logic in_ready,
    // Draining side
    output logic out_valid,
    output logic [WIDTH-1:0] out_data,
    input wire logic out_ready
);

    localparam int unsigned AW = $clog2(DEPTH);

    typedef struct packed {
        logic [AW-1:0] wr_ptr;
        logic [AW-1:0] rd_ptr;
        logic [AW:0] count;
    } fifo_regs_t;

    fifo_regs_t s_r;
    fifo_regs_t s_nxt;
    logic [WIDTH-1:0] mem [DEPTH];
    logic push;
    logic pop;

    assign in_ready = (s_r.count != (AW+1)'(DEPTH));
    assign out_valid = (s_r.count != '0);
    assign out_data = mem[s_r.rd_ptr];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_comb
    begin
        s_nxt = s_r;
        if (push)
        begin
            s_nxt.wr_ptr = s_r.wr_ptr + AW'(1);
        end
        if (pop)
        begin
            s_nxt.rd_ptr = s_r.rd_ptr + AW'(1);
        end
        case ({push, pop})
            2'b10: s_nxt.count = s_r.count + (AW+1)'(1);
            2'b01: s_nxt.count = s_r.count - (AW+1)'(1);
            default: s_nxt.count = s_r.count;
        endcase
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            s_r <= '0;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    // Storage carries no reset; only the pointers and the count need a defined value
    always_ff @(posedge clk)
    begin
        if (push)
        begin
            mem[s_r.wr_ptr] <= in_data;
        end
    end

endmodule : cfg_byte_fifo

// ==== rtl/serial_bit_capture.sv ====
// Purpose: Link-side shifter that turns serial configuration bits into bytes
// Assumes: Runs on config_bit_clock, which may stop between downloads
// Notes: Each finished byte is held and announced by a toggle for the ref_clk side
module serial_bit_capture
    import ps_cfg_pkg::*;
(
    // Link clock and reset
    input wire logic config_bit_clock,
    input wire logic rst,
    // From the ref_clk side
    input wire logic accept_level,
    // Serial pin
    input wire logic serial_config_data,
    // To the ref_clk side
    output logic [BYTE_W-1:0] byte_hold,
    output logic byte_toggle
);

    typedef struct packed {
        logic acc_meta;
        logic acc_sync;
        logic [BYTE_W-1:0] shift;
        logic [2:0] bit_cnt;
        logic [BYTE_W-1:0] hold;
        logic toggle;
    } cap_regs_t;

    cap_regs_t s_r;
    cap_regs_t s_nxt;

    assign byte_hold = s_r.hold;
    assign byte_toggle = s_r.toggle;

    always_comb
    begin
        s_nxt = s_r;
        s_nxt.acc_meta = accept_level;
        s_nxt.acc_sync = s_r.acc_meta;
        if (!s_r.acc_sync)
        begin
            // Realign on every new download
            s_nxt.bit_cnt = 3'h0;
        end
        else
        begin
            // Bits go in least significant first, one per rising edge
            s_nxt.shift = {serial_config_data, s_r.shift[BYTE_W-1:1]};
            s_nxt.bit_cnt = s_r.bit_cnt + 3'h1;
            if (s_r.bit_cnt == 3'h7)
            begin
                s_nxt.hold = {serial_config_data, s_r.shift[BYTE_W-1:1]};
                s_nxt.toggle = !s_r.toggle;
            end
        end
    end

    always_ff @(posedge config_bit_clock or posedge rst)
    begin
        if (rst)
        begin
            s_r <= '0;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

endmodule : serial_bit_capture

// ==== test/cable_host_model.sv ====
// Purpose: Cable host that drives the request pin, link clock and serial data
// Assumes: Link clock and data idle high through board pull-ups
// Notes: The link clock only runs inside a download, as a real cable does
module cable_host_model
    import ps_cfg_pkg::*;
(
    // Pins toward the device
    output logic config_request_n,
    output logic config_bit_clock,
    output logic serial_config_data,
    // Resolved shared wires
    input wire logic status_wire,
    input wire logic done_wire
);
    timeunit 1ns;
    timeprecision 100ps;

    initial
    begin
        config_request_n = 1'b1;
        config_bit_clock = 1'b1;
        serial_config_data = 1'b1;
    end

    // Data changes on the falling half so it is settled at the rising edge
    task automatic clock_bit(input logic b);
        config_bit_clock = 1'b0;
        serial_config_data = b;
        #40;
        config_bit_clock = 1'b1;
        #40;
    endtask : clock_bit

    // A fresh low pulse is needed even after power-up and after any error
    task automatic start();
        config_request_n = 1'b0;
        #40;
        config_request_n = 1'b1;
        wait (status_wire === 1'b1);
        #80;
        // Two idle clocks carry the accept level across; a third would be taken as data
        repeat (2) clock_bit(1'b1);
    endtask : start

    task automatic send_byte(input logic [BYTE_W-1:0] b);
        for (int k = 0; k < BYTE_W; k++)
            clock_bit(b[k]);
    endtask : send_byte

    // Bounded, since a chained peer may hold done low for a long time
    task automatic finish();
        int k;
        k = 0;
        while (done_wire !== 1'b1 && k < 16)
        begin
            clock_bit(1'b1);
            k++;
        end
    endtask : finish

endmodule : cable_host_model

// ==== test/passive_serial_config_slave_tb.sv ====
// Purpose: Self-checking bench of the passive serial configuration front end
// Assumes: Shortened power-on count; sink stalls at random
// Notes: A chained peer is modelled by extra pull-downs on status and done
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin errors++; \
    $display("mismatch %s exp %0h got %0h", nm, e, g); end end

module passive_serial_config_slave_tb
    import ps_cfg_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    localparam int POR_SIM = 20;
    localparam int CFG_N = 20;
    localparam int INIT_CYC = INIT_TICKS * OSC_DIV;

    logic ref_clk, rst, sink_on, peer_status_low, peer_done_low, cfg_out_ready;
    logic status_oe_n, done_oe_n, st_out, dn_out, chain_out_n, out_valid;
    logic io_oe_n, user_mode, err_seen;
    logic [BYTE_W-1:0] out_data;
    wire link_clk, sdata, req_n;
    wire status_wire = (status_oe_n ? 1'b1 : st_out) & ~peer_status_low;
    wire done_wire = (done_oe_n ? 1'b1 : dn_out) & ~peer_done_low;
    int errors, n_compared, seed, k, e_byte;
    int exp_q[$];

    always #2 ref_clk = ~ref_clk;

    passive_serial_config_slave #(.POR_CYCLES(POR_SIM), .CFG_BYTES(CFG_N)) uut (
        .ref_clk(ref_clk), .rst(rst),
        .config_bit_clock(link_clk), .serial_config_data(sdata),
        .config_request_n(req_n),
        .config_status_n_in(status_wire), .config_status_n_out(st_out),
        .config_status_n_oe_n(status_oe_n),
        .config_done_in(done_wire), .config_done_out(dn_out), .config_done_oe_n(done_oe_n),
        .chain_enable_in_n(1'b0), .chain_enable_out_n(chain_out_n),
        .user_init_clock(1'b0), .user_init_clock_en(1'b0),
        .cfg_out_valid(out_valid), .cfg_out_data(out_data), .cfg_out_ready(cfg_out_ready),
        .cfg_data_error(1'b0),
        .user_io_oe_n(io_oe_n), .user_mode(user_mode), .config_error_seen(err_seen)
    );

    cable_host_model host (
        .config_request_n(req_n), .config_bit_clock(link_clk),
        .serial_config_data(sdata), .status_wire(status_wire), .done_wire(done_wire)
    );

    always @(negedge ref_clk)
        cfg_out_ready <= sink_on && ($random(seed) & 1);

    // Every byte taken by the sink must be the next one the host sent
    always @(posedge ref_clk)
        if (!rst && out_valid === 1'b1 && cfg_out_ready)
        begin
            e_byte = (exp_q.size() == 0) ? -1 : exp_q.pop_front();
            `CHK("cfg_out_data", e_byte, out_data)
        end

    task automatic wait_cyc(input int n);
        repeat (n) @(negedge ref_clk);
    endtask : wait_cyc

    task automatic send_n(input int n, input bit keep);
        logic [BYTE_W-1:0] b;
        for (int i = 0; i < n; i++)
        begin
            b = 8'($random(seed));
            if (keep)
                exp_q.push_back(b);
            host.send_byte(b);
        end
    endtask : send_n

    task automatic final_report();
        $display("counts: compared %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : final_report

    // About 60 bytes at 640 ns each plus initialization, with wide margin
    initial
    begin
        #(400 * 640);
        errors++;
        final_report();
    end

    initial
    begin
        ref_clk = 1'b0;
        rst = 1'b1;
        {sink_on, peer_status_low, peer_done_low} = 3'h0;
        errors = 0;
        n_compared = 0;
        seed = 87329;
        wait_cyc(10);
        `CHK("status_oe_n", 1'b0, status_oe_n)
        `CHK("user_io_oe_n", 1'b1, io_oe_n)
        rst = 1'b0;
        wait_cyc(POR_SIM - 5);
        `CHK("status_oe_n", 1'b0, status_oe_n)
        `CHK("status wire", 1'b0, status_wire)
        wait_cyc(15);
        `CHK("status_oe_n", 1'b1, status_oe_n)
        `CHK("user_io_oe_n", 1'b1, io_oe_n)
        $display("test power-on done");

        // Full download, FIFO filled while the sink stalls, peer holds done
        peer_done_low = 1'b1;
        host.start();
        send_n(16, 1);
        wait_cyc(20);
        `CHK("cfg_out_valid", 1'b1, out_valid)
        `CHK("done_oe_n", 1'b0, done_oe_n)
        sink_on = 1'b1;
        send_n(CFG_N - 16, 1);
        host.finish();
        wait_cyc(100);
        `CHK("bytes left", 0, exp_q.size())
        `CHK("done_oe_n", 1'b1, done_oe_n)
        `CHK("chain_enable_out_n", 1'b0, chain_out_n)
        `CHK("user_mode", 1'b0, user_mode)
        peer_done_low = 1'b0;
        for (k = 0; k < 4000 && user_mode !== 1'b1; k++)
            @(negedge ref_clk);
        `CHK("init window", 1'b1, (k >= INIT_CYC - 8 && k <= INIT_CYC + 16))
        `CHK("user_io_oe_n", 1'b0, io_oe_n)
        $display("test download done");

        // Peer pulls shared status low mid download; later bits are refused
        host.start();
        send_n(2, 1);
        wait_cyc(40);
        peer_status_low = 1'b1;
        wait_cyc(5);
        peer_status_low = 1'b0;
        send_n(CFG_N - 2, 0);
        host.finish();
        wait_cyc(50);
        `CHK("done_oe_n", 1'b0, done_oe_n)
        `CHK("done wire", 1'b0, done_wire)
        `CHK("cfg_out_valid", 1'b0, out_valid)
        `CHK("user_mode", 1'b0, user_mode)
        $display("test shared status done");

        // Overrun: sink stalled, 16 queued, one pending, the next one overruns
        host.start();
        sink_on = 1'b0;
        send_n(18, 0);
        for (k = 0; k < 40 && err_seen !== 1'b1; k++)
            @(negedge ref_clk);
        `CHK("config_error_seen", 1'b1, err_seen)
        `CHK("status_oe_n", 1'b0, status_oe_n)
        wait_cyc(200);
        `CHK("done_oe_n", 1'b0, done_oe_n)
        `CHK("user_mode", 1'b0, user_mode)
        $display("test overrun done");
        final_report();
    end

endmodule : passive_serial_config_slave_tb
